//--- bench/bmcc_ee_model.sv
// Behavioural two-wire EEPROM responder that answers the power-up read walk.
`timescale 1ns/1ps
module bmcc_ee_model (
    input  wire logic       i_clk,     // Core clock.
    input  wire logic       i_req,     // Read request pulse.
    input  wire logic [7:0] i_addr,    // Byte address.
    input  wire logic       i_present, // High when the part answers.
    input  wire logic [7:0] i_sig,     // Content of both signature bytes.
    input  wire logic [7:0] i_desig,   // Content of the designator byte.
    input  wire logic [3:0] i_delay,   // Answer latency in cycles, at least one.
    output logic            o_done,    // One-cycle answer pulse.
    output logic            o_ack,     // Answered flag.
    output logic [7:0]      o_data     // Byte read.
);
    logic [3:0] cnt = 4'h0; // Cycles left until the answer.
    initial o_data = 8'hA5;
    // ==================================================
    // Answer engine
    // ==================================================
    // Outside an answer the data toggles so a stale byte can never be mistaken for a read.
    always @(posedge i_clk) begin
        o_done <= 1'b0;
        o_ack  <= 1'b0;
        o_data <= ~o_data;
        if (i_req) begin
            cnt <= i_delay;
        end else if (cnt == 4'h1) begin
            o_done <= 1'b1;
            o_ack  <= i_present;
            o_data <= (i_addr == 8'h04) ? i_desig : i_sig;
        end
        if (!i_req && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

//--- bench/tb_bridge_mode_config_control.sv
// Self-checking testbench for the bridge mode and configuration control block.
`timescale 1ns/1ps
module tb_bridge_mode_config_control;
    import bmcc_pkg::*;
    localparam int unsigned SP = 50; // Shortened sample period.
    logic i_clk = 0, i_rst_n = 0, ena = 1, vbus = 1, susp = 0, cv = 0, csof = 0, pres = 1, got, seen;
    logic [7:0] cd = 8'h00, sig = 8'h4D, desig = 8'h5A, rd_addr, ee_data, s, rz, rsrc, ra, rfl;
    logic [3:0] dly = 4'h3;
    logic rq, ee_done, ee_ack, cvld, bdone, tmode, conn, hs, ls, drv, run, lp, wake;
    bmcc_cmd_t cmd, c;
    integer seed = 14000, mismatches = 0, cmp_count = 0, i;
    logic [31:0] len;
    bmcc_top #(.SAMPLE_PERIOD(SP)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ata_bus_enable(ena),
        .i_vbus_present(vbus), .i_suspend(susp), .o_ee_rd_req(rq), .o_ee_rd_addr(rd_addr), .i_ee_done(ee_done),
        .i_ee_ack(ee_ack), .i_ee_data(ee_data), .i_cbw_valid(cv), .i_cbw_sof(csof), .i_cbw_data(cd),
        .o_cmd_valid(cvld), .o_cmd(cmd), .o_boot_done(bdone), .o_test_mode(tmode), .o_usb_connect(conn),
        .o_hs_enable(hs), .o_ls_enable(ls), .o_ata_drive_en(drv), .o_ata_run(run), .o_low_power(lp), .o_wake(wake));
    bmcc_ee_model u_ee (.i_clk(i_clk), .i_req(rq), .i_addr(rd_addr), .i_present(pres), .i_sig(sig),
        .i_desig(desig), .i_delay(dly), .o_done(ee_done), .o_ack(ee_ack), .o_data(ee_data));
    initial forever #5 i_clk = ~i_clk;
    // ==================================================
    // Compare, drive and closing tasks
    // ==================================================
    task chk_bit(input string n, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin mismatches++; $display("Error %s expected %b seen %b", n, e, g); end
    endtask
    task chk_cmd(input bmcc_cmd_t e, input bmcc_cmd_t g);
        cmp_count++;
        if (g !== e) begin mismatches++; $display("Error cmd expected %h seen %h", e, g); end
    endtask
    task report_and_stop;
        $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Inputs always change one nanosecond after the rising edge.
    task step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task boot;
        for (i = 0; i < 300 && bdone !== 1'b1; i++) step(1);
        if (bdone !== 1'b1) begin mismatches++; report_and_stop; end
    endtask
    task wait_wake;
        seen = 0;
        repeat (SP + 3) begin step(1); seen |= wake; end
    endtask
    // One whole wrapper; the decoded pulse is looked at in the cycle after byte 30.
    task send(input logic [7:0] d0, sb, z, src, a, input logic [31:0] ln, input logic [7:0] fl);
        logic [7:0] b [31];
        for (int k = 0; k < 31; k++) b[k] = (k > 20) ? 8'h00 : 8'($random(seed));
        {b[11], b[10], b[9], b[8]} = ln;
        b[12] = fl; b[15] = d0; b[16] = sb; b[17] = z; b[18] = src; b[19] = a; b[20] = a;
        for (int k = 0; k < 31; k++) begin cv = 1; csof = (k == 0); cd = b[k]; step(1); end
        cv = 0; csof = 0; got = cvld; c = cmd; step(1);
    endtask
    function automatic bmcc_cmd_t exp_cmd(logic [7:0] sb, z, src, a, logic [31:0] ln, logic [7:0] fl);
        exp_cmd.is_cfg = (sb == 8'h26);
        exp_cmd.is_test = (sb == 8'h27);
        exp_cmd.fail = !(sb == 8'h27 || (sb == 8'h26 && z == 8'h00 && src == 8'h02 && a == 8'h00 && ln <= 32'hFF));
        exp_cmd.dir_in = fl[7];
        exp_cmd.len = ln[7:0];
    endfunction
    initial begin #900_000; mismatches++; report_and_stop; end
    // ==================================================
    // Main sequence
    // ==================================================
    initial begin
        step(10); i_rst_n = 1; boot;
        chk_bit("test_mode", 1'b0, tmode);
        chk_bit("hs", 1'b1, hs); chk_bit("ls", 1'b0, ls);
        chk_bit("rd_req", 1'b0, rq); chk_bit("rd_addr", 1'b1, rd_addr == EE_DESIG_ADDR);
        step(SP + 2); chk_bit("connect", 1'b1, conn); chk_bit("drive", 1'b1, drv);
        send(desig, 8'h26, 8'h00, 8'h02, 8'h00, 32'h10, 8'h80); chk_bit("cmd_valid", 1'b0, got);
        susp = 1; ena = 0; wait_wake;
        chk_bit("wake", 1'b1, seen); chk_bit("drive", 1'b0, drv); chk_bit("low_power", 1'b1, lp);
        ena = 1; wait_wake; chk_bit("wake", 1'b1, seen); chk_bit("drive", 1'b1, drv);
        susp = 0; step(SP + 2); ena = 0; step(SP + 2);
        chk_bit("low_power", 1'b1, lp); chk_bit("connect", 1'b0, conn);
        chk_bit("run", 1'b0, run);
        ena = 1; step(SP + 2); boot; step(2);
        chk_bit("connect", 1'b1, conn); chk_bit("low_power", 1'b0, lp);
        vbus = 0; step(SP + 2); chk_bit("connect", 1'b0, conn); vbus = 1;
        i_rst_n = 0; dly = 4'h7; sig = 8'($random(seed)); desig = 8'($random(seed));
        if (sig == 8'h4D) sig = 8'h00;
        step(1); chk_bit("boot_done", 1'b0, bdone); step(9); i_rst_n = 1; boot;
        chk_bit("test_mode", 1'b1, tmode); chk_bit("drive", 1'b0, drv);
        step(SP + 2); chk_bit("connect", 1'b1, conn);
        send(~desig, 8'h26, 8'h00, 8'h02, 8'h00, 32'h10, 8'h00); chk_bit("cmd_valid", 1'b0, got);
        repeat (24) begin
            s = ($random(seed) & 3) == 0 ? 8'($random(seed)) : (($random(seed) & 1) ? 8'h26 : 8'h27);
            len = {$random(seed)} % 301;
            rz = 8'(($random(seed) & 7) == 0); rsrc = 8'(($random(seed) & 7) == 0 ? 3 : 2);
            ra = 8'(($random(seed) & 7) == 0); rfl = 8'($random(seed));
            send(desig, s, rz, rsrc, ra, len, rfl);
            chk_bit("cmd_valid", 1'b1, got);
            chk_cmd(exp_cmd(s, rz, rsrc, ra, len, rfl), c);
        end
        i_rst_n = 0; pres = 0; step(10); i_rst_n = 1; boot;
        chk_bit("test_mode", 1'b1, tmode); chk_bit("drive", 1'b0, drv);
        send(DESIG_DEFAULT, 8'h26, 8'h00, 8'h02, 8'h00, 32'h20, 8'h80); chk_bit("cmd_valid", 1'b1, got);
        chk_cmd(exp_cmd(8'h26, 8'h00, 8'h02, 8'h00, 32'h20, 8'h80), c);
        report_and_stop;
    end
endmodule

//--- design/bmcc_pkg.sv
// Shared constants, types and timing for the bridge mode and configuration control block.
package bmcc_pkg;

    // ==========================================================================
    // Clock and timing
    // ==========================================================================
    localparam int unsigned CLK_HZ          = 100_000_000; // Core clock rate in hertz.
    localparam int unsigned SAMPLE_RATE_HZ  = 50;          // Enable-pin samples per second.
    localparam int unsigned VBUS_POLL_MS    = 20;          // Supply-present poll period in ms.
    localparam int unsigned RESET_HOLD_MS   = 10;          // Least hold time of the chip reset in ms.
    localparam int unsigned SAMPLE_CYCLES   = CLK_HZ / SAMPLE_RATE_HZ;       // Cycles per enable sample.
    localparam int unsigned VBUS_CYCLES     = CLK_HZ / 1000 * VBUS_POLL_MS;  // Cycles per supply poll.
    localparam int unsigned RESET_CYCLES    = CLK_HZ / 1000 * RESET_HOLD_MS; // Cycles of reset hold.

    // ==========================================================================
    // EEPROM layout
    // ==========================================================================
    localparam logic [7:0] EE_SIG_ADDR0     = 8'h00; // First signature byte.
    localparam logic [7:0] EE_SIG_ADDR1     = 8'h01; // Second signature byte.
    localparam logic [7:0] EE_DESIG_ADDR    = 8'h04; // Vendor command designator location.
    localparam logic [7:0] EE_SIG_VALUE     = 8'h4D; // Value each signature byte must hold.
    localparam logic [7:0] DESIG_DEFAULT    = 8'h24; // Designator used when no EEPROM answers.

    // ==========================================================================
    // Command wrapper layout (byte indices within the 31-byte wrapper)
    // ==========================================================================
    localparam logic [4:0] CBW_LEN_B0       = 5'h08; // Transfer length, least significant byte.
    localparam logic [4:0] CBW_LEN_B3       = 5'h0B; // Transfer length, most significant byte.
    localparam logic [4:0] CBW_FLAGS        = 5'h0C; // Flags byte.
    localparam int unsigned CBW_DIR_BIT     = 7;     // Direction bit within the flags byte.
    localparam logic [4:0] CBW_CB0          = 5'h0F; // First command block byte.
    localparam logic [4:0] CBW_LAST         = 5'h1E; // Last wrapper byte.

    // ==========================================================================
    // Command block values
    // ==========================================================================
    localparam logic [7:0] SUB_CONFIG       = 8'h26; // Subcommand of EEPROM access.
    localparam logic [7:0] SUB_BOARD_TEST   = 8'h27; // Subcommand of board test.
    localparam logic [7:0] SRC_EEPROM       = 8'h02; // Memory source code for the EEPROM.
    localparam logic [7:0] BYTE_ZERO        = 8'h00; // Required value of zero fields.
    localparam logic [31:0] CFG_MAX_LEN     = 32'h0000_00FF; // Largest configuration transfer.

    // Decoded vendor command handed to the command engine.
    typedef struct packed {
        logic       is_cfg;  // EEPROM access command.
        logic       is_test; // Board test command.
        logic       fail;    // Command is rejected; report failure in status.
        logic       dir_in;  // Data flows to the host.
        logic [7:0] len;     // Transfer length, low byte.
    } bmcc_cmd_t;

    // Power-up EEPROM walk.
    typedef enum logic [1:0] {
        BOOT_REQ,
        BOOT_WAIT,
        BOOT_DONE
    } bmcc_boot_t;

endpackage

//--- design/bmcc_tick.sv
// Free-running divider that emits a one-cycle enable pulse every CYCLES clocks.
`timescale 1ns/1ps
module bmcc_tick #(
    parameter int unsigned CYCLES = 2_000_000 // Period of the pulse in clock cycles.
) (
    input  wire logic i_clk,   // Core clock.
    input  wire logic i_rst_n, // Synchronised reset, active low.
    output logic      o_tick   // One-cycle pulse at the end of each period.
);
    logic [31:0] count; // Cycles elapsed in the current period.

    // ==========================================================================
    // Divider
    // ==========================================================================
    // The counter wraps at the period end; the pulse is registered to stay glitch free.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count  <= 32'h0000_0000;
            o_tick <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count  <= 32'h0000_0000;
            o_tick <= 1'b1;
        end else begin
            count  <= count + 32'h0000_0001;
            o_tick <= 1'b0;
        end
    end
endmodule

//--- design/bmcc_top.sv
// Power-up mode selection, vendor command decode and bus-enable power control.
`timescale 1ns/1ps
module bmcc_top
    import bmcc_pkg::*;
#(
    parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES, // Cycles between enable samples and supply polls.
    parameter logic [7:0]  DESIG_NO_EE   = DESIG_DEFAULT  // Designator without EEPROM; value is arbitrary.
) (
    input  wire logic       i_clk,             // Core clock, 100 MHz.
    input  wire logic       i_rst_n,           // Chip reset, active low, asynchronous.
    input  wire logic       i_ata_bus_enable,  // ATA bus enable pin.
    input  wire logic       i_vbus_present,    // Bus supply present pin.
    input  wire logic       i_suspend,         // USB core reports bus suspend.
    output logic            o_ee_rd_req,       // One-cycle EEPROM read request.
    output logic [7:0]      o_ee_rd_addr,      // EEPROM byte address of the request.
    input  wire logic       i_ee_done,         // One-cycle answer to a read.
    input  wire logic       i_ee_ack,          // EEPROM answered with the pulse above.
    input  wire logic [7:0] i_ee_data,         // Byte read, valid with the answer.
    input  wire logic       i_cbw_valid,       // Wrapper byte valid.
    input  wire logic       i_cbw_sof,         // Marks wrapper byte 0.
    input  wire logic [7:0] i_cbw_data,        // Wrapper byte.
    output logic            o_cmd_valid,       // One-cycle pulse: decoded vendor command.
    output bmcc_cmd_t       o_cmd,             // Decoded vendor command.
    output logic            o_boot_done,       // Power-up EEPROM walk finished.
    output logic            o_test_mode,       // Board manufacturing test mode.
    output logic            o_usb_connect,     // D+ pull-up attached.
    output logic            o_hs_enable,       // High-speed chirp permitted.
    output logic            o_ls_enable,       // Low-speed signalling permitted.
    output logic            o_ata_drive_en,    // ATA pin output enable.
    output logic            o_ata_run,         // ATA engine may run.
    output logic            o_low_power,       // Low-power state.
    output logic            o_wake             // One-cycle wake out of suspend.
);

    // ==========================================================================
    // Reset synchroniser
    // ==========================================================================
    logic rst_meta; // First stage, read only by the second.
    logic rst_n;    // Released copy used by all logic.

    // The whole chip is reset at once, whatever hold time the pin is given.
    // Assertion is immediate, release takes two edges so no flop leaves reset metastable.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==========================================================================
    // Sampling timebase
    // ==========================================================================
    logic tick;       // End of a sampling period.
    logic first;      // High for the first cycle after reset release.
    logic sample_now; // Inputs are sampled in this cycle.

    // One divider serves both polls, since both run at a 20 ms period.
    bmcc_tick #(
        .CYCLES (SAMPLE_PERIOD)
    ) u_tick (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .o_tick  (tick)
    );

    // The start-up poll happens at once instead of waiting a full period.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end

    assign sample_now = tick | first;

    // ==========================================================================
    // Power-up EEPROM walk
    // ==========================================================================
    bmcc_boot_t boot_state; // Walk state.
    logic       sig_ok;     // Signature bytes seen so far are all valid.
    logic [7:0] designator; // Vendor command designator in use.
    logic       restart;    // Return to the post-reset state.

    // Reads bytes 0, 1 and 4; a missing EEPROM ends the walk at the first silent answer.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_state   <= BOOT_REQ;
            o_ee_rd_addr <= EE_SIG_ADDR0;
            sig_ok       <= 1'b1;
            designator   <= DESIG_DEFAULT;
            o_test_mode  <= 1'b0;
        end else if (restart) begin
            boot_state   <= BOOT_REQ;
            o_ee_rd_addr <= EE_SIG_ADDR0;
            sig_ok       <= 1'b1;
        end else begin
            unique case (boot_state)
                BOOT_REQ: begin
                    boot_state <= BOOT_WAIT;
                end
                BOOT_WAIT: begin
                    if (i_ee_done && !i_ee_ack) begin
                        // Nothing answered: no EEPROM fitted.
                        designator  <= DESIG_NO_EE;
                        o_test_mode <= 1'b1;
                        boot_state  <= BOOT_DONE;
                    end else if (i_ee_done && o_ee_rd_addr == EE_DESIG_ADDR) begin
                        designator  <= i_ee_data;
                        o_test_mode <= !sig_ok;
                        boot_state  <= BOOT_DONE;
                    end else if (i_ee_done) begin
                        // Keep walking on a bad byte so test mode still knows its designator.
                        sig_ok       <= sig_ok && (i_ee_data == EE_SIG_VALUE);
                        o_ee_rd_addr <= (o_ee_rd_addr == EE_SIG_ADDR0) ? EE_SIG_ADDR1 : EE_DESIG_ADDR;
                        boot_state   <= BOOT_REQ;
                    end
                end
                // Only a reset or a restart leaves the done state.
                BOOT_DONE: begin
                    boot_state <= BOOT_DONE;
                end
            endcase
        end
    end

    // The request stays low while the internal reset is held, so the EEPROM sees no stray read.
    assign o_ee_rd_req = rst_n && (boot_state == BOOT_REQ);
    assign o_boot_done = (boot_state == BOOT_DONE);

    // ==========================================================================
    // Bus enable and supply polling
    // ==========================================================================
    logic ata_s;    // Last sampled bus enable.
    logic vbus_s;   // Last sampled supply present.
    logic ata_rise; // Enable rose between two samples.
    logic ata_fall; // Enable fell between two samples.
    logic lp_ata;   // Low power held by a disabled bus.
    logic ata_drv;  // ATA pins are driven.

    // Edges are judged only against the previous sample, never against the raw pin.
    assign ata_rise = sample_now && i_ata_bus_enable && !ata_s;
    assign ata_fall = sample_now && !i_ata_bus_enable && ata_s;

    // A pulse narrower than a period can be missed; the pin is meant to change rarely.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ata_s  <= 1'b1;
            vbus_s <= 1'b0;
        end else if (sample_now) begin
            ata_s  <= i_ata_bus_enable;
            vbus_s <= i_vbus_present;
        end
    end

    // Test mode ignores the enable pin, so edges there change nothing.
    assign restart = ata_rise && lp_ata && !i_suspend && !o_test_mode;

    // Low power caused by the enable pin, kept apart from bus suspend.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_ata <= 1'b0;
        end else if (ata_fall && !i_suspend && !o_test_mode) begin
            lp_ata <= 1'b1;
        end else if (restart) begin
            lp_ata <= 1'b0;
        end
    end

    // Pin drive follows the sampled enable, also while suspended.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ata_drv <= 1'b0;
        end else if (sample_now) begin
            ata_drv <= i_ata_bus_enable;
        end
    end

    // A one-cycle wake lets the suspended core update the pin drive, then it sleeps again.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= i_suspend && (ata_rise || ata_fall) && !o_test_mode;
        end
    end

    // Pin and pull-up enables come from registered samples and the walk state, so they move only after a sample or when the walk ends.
    assign o_ata_drive_en = ata_drv && !o_test_mode && o_boot_done;
    assign o_ata_run      = o_ata_drive_en && !lp_ata;
    assign o_low_power    = lp_ata || (i_suspend && !o_wake);
    assign o_usb_connect  = vbus_s && o_boot_done && !lp_ata && (ata_s || o_test_mode);
    assign o_hs_enable    = 1'b1;
    assign o_ls_enable    = 1'b0;

    // ==========================================================================
    // Command wrapper decode
    // ==========================================================================
    logic [4:0]  idx;      // Index of the next wrapper byte.
    logic [31:0] xfer_len; // Transfer length field.
    logic        dir_in;   // Direction flag.
    logic [7:0]  cb [6];   // Command block bytes 0 to 5.
    logic        cfg_ok;   // EEPROM access fields hold their required values.
    logic        is_cfg;   // Byte 1 selects EEPROM access.
    logic        is_test;  // Byte 1 selects board test.
    logic [4:0]  cb_pos;   // Offset of the byte within the command block.

    // Only the first six command block bytes carry checked fields; the reserved tail is ignored.
    assign cb_pos = idx - CBW_CB0;

    // Bytes are taken whenever valid; the start marker resynchronises the index.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            idx      <= 5'h00;
            xfer_len <= 32'h0000_0000;
            dir_in   <= 1'b0;
            cb       <= '{default: 8'h00};
        end else if (i_cbw_valid) begin
            if (i_cbw_sof || idx == CBW_LAST) begin
                idx <= i_cbw_sof ? 5'h01 : 5'h00;
            end else begin
                idx <= idx + 5'h01;
            end
            if (!i_cbw_sof && idx >= CBW_LEN_B0 && idx <= CBW_LEN_B3) begin
                xfer_len[8*(idx-CBW_LEN_B0) +: 8] <= i_cbw_data;
            end
            if (!i_cbw_sof && idx == CBW_FLAGS) begin
                dir_in <= i_cbw_data[CBW_DIR_BIT];
            end
            if (!i_cbw_sof && idx >= CBW_CB0 && cb_pos < 5'h06) begin
                cb[cb_pos[2:0]] <= i_cbw_data;
            end
        end
    end

    // Field checks work on stored bytes and are settled long before byte 30 closes the wrapper.
    assign is_cfg  = (cb[1] == SUB_CONFIG);
    assign is_test = (cb[1] == SUB_BOARD_TEST);
    assign cfg_ok  = (cb[2] == BYTE_ZERO) && (cb[3] == SRC_EEPROM)
                  && (cb[4] == BYTE_ZERO) && (cb[5] == BYTE_ZERO)
                  && (xfer_len <= CFG_MAX_LEN);

    // A finished wrapper addressed by the designator yields one decoded command in test mode.
    // The command fields hold until the next accepted wrapper, so a slow reader still finds them.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_cmd_valid <= 1'b0;
            o_cmd       <= '0;
        end else begin
            o_cmd_valid <= 1'b0;
            if (i_cbw_valid && !i_cbw_sof && idx == CBW_LAST && o_test_mode && cb[0] == designator) begin
                o_cmd_valid  <= 1'b1;
                o_cmd.is_cfg <= is_cfg;
                o_cmd.is_test <= is_test;
                o_cmd.fail   <= !(is_test || (is_cfg && cfg_ok));
                o_cmd.dir_in <= dir_in;
                o_cmd.len    <= xfer_len[7:0];
            end
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    logic [31:0] gap;  // Cycles since the last tick.
    logic        seen; // A tick has occurred since reset.

    // The helper logic below feeds the assertions only and carries no function.
    // Helper counter measuring the spacing of samples.
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap  <= 32'h0000_0000;
            seen <= 1'b0;
        end else begin
            gap  <= tick ? 32'h0000_0000 : gap + 32'h0000_0001;
            seen <= seen || tick;
        end
    end

    sequence wake_blip;
        o_wake ##1 !o_wake;
    endsequence

    sequence walk_fail;
        (boot_state == BOOT_WAIT && i_ee_done && !i_ee_ack) ##1 o_boot_done;
    endsequence

    tick_spacing_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        tick && seen |-> gap == 32'(SAMPLE_PERIOD - 1)) else $error("sample spacing wrong");
    fall_detach_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        ata_fall && !i_suspend && !o_test_mode |=> o_low_power && !o_usb_connect && !o_ata_run)
        else $error("enable fall did not detach");
    float_pins_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        sample_now && !i_ata_bus_enable |=> !o_ata_drive_en) else $error("ATA pins driven while disabled");
    rise_restart_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        restart |=> boot_state == BOOT_REQ && o_ee_rd_addr == EE_SIG_ADDR0 && !lp_ata)
        else $error("enable rise did not restart");
    suspend_wake_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_suspend && !o_test_mode && (ata_rise || ata_fall) |=> wake_blip)
        else $error("suspend wake missing");
    vbus_poll_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        sample_now |=> vbus_s == $past(i_vbus_present)) else $error("supply not polled");
    pullup_rel_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        !vbus_s |-> !o_usb_connect) else $error("pull-up kept without supply");
    normal_sig_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        $rose(o_boot_done) && !o_test_mode |-> sig_ok) else $error("normal mode without signature");
    no_eeprom_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        walk_fail |-> o_test_mode) else $error("missing EEPROM not sent to test mode");
    long_cfg_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        o_cmd_valid && o_cmd.is_cfg && $past(xfer_len) > CFG_MAX_LEN |-> o_cmd.fail)
        else $error("oversized transfer accepted");
    test_idle_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        o_test_mode |-> !o_ata_drive_en && !o_ls_enable) else $error("test mode drove ATA");
    // A decoded command may only leave the block while test mode is in force.
    cmd_test_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        o_cmd_valid |-> o_test_mode) else $error("vendor command outside test mode");

endmodule
